// file: design/phs_port_handshake.sv
`timescale 1ns/100ps
`default_nettype none

module phs_port_handshake import phs_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic full_reset_i,
  input wire logic stop_recovery_i,
  // Software access to port 2
  input wire logic p2_wr_i,
  input wire logic [7:0] p2_wdata_i,
  input wire logic p2_rd_i,
  output logic [7:0] p2_rdata_o,
  output logic rd_valid_o,
  // Software access to mode registers and port 3
  input wire logic p2m_wr_i,
  input wire logic [7:0] p2m_wdata_i,
  input wire logic p3m_wr_i,
  input wire logic [7:0] p3m_wdata_i,
  input wire logic p3_wr_i,
  input wire logic [7:0] p3_wdata_i,
  output logic [7:0] p3_rdata_o,
  // Special function selects and sources
  input wire logic strobed_input_i,
  input wire logic cmp_out_en_i,
  input wire logic comparator_one_result_i,
  input wire logic comparator_two_result_i,
  input wire logic serial_en_i,
  input wire logic serial_tx_i,
  input wire logic spi_en_i,
  input wire logic spi_select_i,
  input wire logic spi_clock_line_i,
  input wire logic timer_out_en_i,
  input wire logic timer_out_i,
  output logic serial_receive_in_o,
  output logic timer_in_o,
  // Interrupt requests
  output logic interrupt_request_zero_o,
  output logic interrupt_request_one_o,
  output logic interrupt_request_two_o,
  output logic interrupt_request_three_o,
  // Port pins
  input wire logic [7:0] p2_pin_i,
  output logic [7:0] p2_pin_o,
  output logic [7:0] p2_pin_oe_o,
  input wire logic [3:0] p3_pin_i,
  output logic [7:4] p3_pin_o,
  output logic [1:0] hs_state_o
);

  // ==========================================================
  // Input synchroniser
  // Three stages; a change counts once stages two and three agree.
  logic [PHS_SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      filt_q <= '1;
    end else begin
      s1_q <= {p3_pin_i, p2_pin_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Per line, so a busy line never holds back the others
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= '1;
    end else begin
      prev_q <= filt_q;
    end
  end

  logic [7:0] p2_in;
  logic [3:0] p3_in, p3_fall;
  assign p2_in = filt_q[7:0];
  assign p3_in = filt_q[11:8];
  assign p3_fall = prev_q[11:8] & ~p3_in;

  // ==========================================================
  // Mode and data registers
  logic [7:0] p2m_q, p3m_q, p3_out_q, p2_out_q;
  logic do_full_reset;
  assign do_full_reset = full_reset_i && !stop_recovery_i;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p2m_q <= PHS_P2M_RESET;
      p3m_q <= PHS_P3M_RESET;
      p3_out_q <= PHS_P3_OUT_RESET;
    end else if (do_full_reset) begin
      p2m_q <= PHS_P2M_RESET;
      p3m_q <= PHS_P3M_RESET;
      p3_out_q <= PHS_P3_OUT_RESET;
    end else begin
      if (p2m_wr_i) begin
        p2m_q <= p2m_wdata_i;
      end
      if (p3m_wr_i) begin
        p3m_q <= p3m_wdata_i;
      end
      if (p3_wr_i) begin
        p3_out_q <= p3_wdata_i;
      end
    end
  end

  // Written data is never protected: a write always replaces it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p2_out_q <= PHS_BYTE_ZERO;
    end else if (p2_wr_i) begin
      p2_out_q <= p2_wdata_i;
    end
  end

  logic hs_en, hs_in_mode, hs_out_mode, analog, strobe_line;
  assign hs_en = p3m_q[PHS_P3M_HS2_BIT];
  assign hs_in_mode = hs_en && p2m_q[PHS_P2_HS_DIR_BIT];
  assign hs_out_mode = hs_en && !p2m_q[PHS_P2_HS_DIR_BIT];
  assign analog = p3m_q[PHS_P3M_ANALOG_BIT];
  // Line 1 carries the strobe in input mode and ready in output mode
  assign strobe_line = p3_in[PHS_L1];

  // ==========================================================
  // Two-entry capture buffer; software reads pop it
  logic [7:0] buf_q [PHS_BUF_DEPTH];
  logic [1:0] cnt_q;
  logic rd_ptr_q, wr_ptr_q, push, pop, buf_ready;
  assign rd_valid_o = (cnt_q != PHS_CNT_ZERO);
  assign buf_ready = (cnt_q != PHS_CNT_FULL);
  assign pop = p2_rd_i && rd_valid_o && hs_in_mode;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= PHS_CNT_ZERO;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      buf_q[0] <= PHS_BYTE_ZERO;
      buf_q[1] <= PHS_BYTE_ZERO;
    end else begin
      if (push) begin
        buf_q[wr_ptr_q] <= p2_in;
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + PHS_CNT_ONE;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - PHS_CNT_ONE;
      end
    end
  end

  // ==========================================================
  // Handshake sequencer
  phs_state_t state_q;
  logic [7:0] drive_q;
  logic dav_out_q, pend_q, start, hs_event;

  // Interlocked input captures only when nothing is pending; strobed input
  // uses the buffer slack, and a full buffer ignores the strobe.
  assign push = hs_in_mode && p3_fall[PHS_L1] &&
                (strobed_input_i ? buf_ready : (state_q == PHS_IDLE && !rd_valid_o));
  assign start = hs_out_mode && state_q == PHS_IDLE && (p2_wr_i || pend_q) && strobe_line;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= PHS_IDLE;
    end else if (!hs_en || do_full_reset) begin
      state_q <= PHS_IDLE;
    end else begin
      case (state_q)
        PHS_IDLE: begin
          if (push && !strobed_input_i) begin
            state_q <= PHS_WAIT;
          end else if (start) begin
            state_q <= PHS_WAIT;
          end
        end
        PHS_WAIT: begin
          if (hs_in_mode && !rd_valid_o && strobe_line) begin
            state_q <= PHS_IDLE;
          end else if (hs_out_mode && p3_fall[PHS_L1]) begin
            state_q <= PHS_DONE;
          end
        end
        PHS_DONE: begin
          if (!hs_out_mode || strobe_line) begin
            state_q <= PHS_IDLE;
          end
        end
        default: state_q <= PHS_IDLE;
      endcase
    end
  end

  // Driven data and strobe; a write outside idle waits for idle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_q <= PHS_BYTE_ZERO;
      dav_out_q <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      if (start) begin
        drive_q <= p2_wr_i ? p2_wdata_i : p2_out_q;
        dav_out_q <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        if (p2_wr_i && hs_out_mode) begin
          pend_q <= 1'b1;
        end
        if (hs_out_mode && state_q == PHS_WAIT && p3_fall[PHS_L1]) begin
          dav_out_q <= 1'b1;
        end
        if (!hs_out_mode) begin
          dav_out_q <= 1'b1;
          pend_q <= 1'b0;
        end
      end
    end
  end

  assign hs_state_o = {state_q == PHS_DONE, state_q == PHS_WAIT};

  // ==========================================================
  // Port 2 pins and reads
  // Open-drain keeps the enable off for ones so the load pulls high.
  logic [7:0] p2_data, hs_bits, p2_drive;
  assign hs_bits = hs_en ? ~(p2m_q ^ {8{p2m_q[PHS_P2_HS_DIR_BIT]}}) : PHS_BYTE_ZERO;
  assign p2_data = hs_out_mode ? ((drive_q & hs_bits) | (p2_out_q & ~hs_bits)) : p2_out_q;
  assign p2_drive = ~p2m_q & (p3m_q[PHS_P3M_PUSHPULL_BIT] ? 8'hFF : ~p2_data);
  assign p2_pin_o = p2_data;
  assign p2_pin_oe_o = p2_drive;
  assign p2_rdata_o = hs_in_mode ? ((buf_q[rd_ptr_q] & hs_bits) | (p2_in & ~hs_bits)) : p2_in;

  // ==========================================================
  // Port 3 output lines and special functions
  logic ready_out;
  // Strobed input leaves ready meaningless but still shows sequence state
  assign ready_out = (state_q == PHS_IDLE);

  always_comb begin
    p3_pin_o = p3_out_q[7:4];
    if (analog && cmp_out_en_i) begin
      p3_pin_o[PHS_L4] = comparator_one_result_i;
    end else if (spi_en_i) begin
      p3_pin_o[PHS_L4] = spi_clock_line_i;
    end
    if (analog && cmp_out_en_i) begin
      p3_pin_o[PHS_L5] = comparator_two_result_i;
    end else if (spi_en_i) begin
      p3_pin_o[PHS_L5] = spi_select_i;
    end
    // Software writes never reach line 6 while handshake owns it
    if (hs_en) begin
      p3_pin_o[PHS_L6] = hs_in_mode ? ready_out : dav_out_q;
    end else if (timer_out_en_i) begin
      p3_pin_o[PHS_L6] = timer_out_i;
    end
    if (analog && cmp_out_en_i) begin
      p3_pin_o[PHS_L7] = comparator_two_result_i;
    end else if (serial_en_i) begin
      p3_pin_o[PHS_L7] = serial_tx_i;
    end
  end

  assign serial_receive_in_o = p3_in[PHS_L0];
  assign timer_in_o = p3_in[PHS_L1];
  // Reads return the driven outputs and the inputs, or comparator results
  assign p3_rdata_o = {p3_pin_o,
                       p3_in[PHS_L3],
                       analog ? comparator_two_result_i : p3_in[PHS_L2],
                       analog ? comparator_one_result_i : p3_in[PHS_L1],
                       p3_in[PHS_L0]};

  // ==========================================================
  // Interrupt requests, one-cycle pulses
  // Line 3 is the shared comparator reference in analog mode, so it is muted.
  assign hs_event = hs_in_mode ? push : (state_q == PHS_WAIT && p3_fall[PHS_L1]);
  assign interrupt_request_three_o = p3_fall[PHS_L0];
  assign interrupt_request_two_o = hs_en ? hs_event : p3_fall[PHS_L1];
  assign interrupt_request_zero_o = p3_fall[PHS_L2];
  assign interrupt_request_one_o = p3_fall[PHS_L3] && !analog;

  // ==========================================================
  // Checks
  latch_holds_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_in_mode && !strobed_input_i && state_q == PHS_WAIT && rd_valid_o && !p2_rd_i
    |=> $stable(buf_q[rd_ptr_q]) && !push)
    else $error("latched byte disturbed before read");
  ready_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_in_mode && state_q == PHS_IDLE |-> p3_pin_o[PHS_L6])
    else $error("ready low while idle");
  capture_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    push |-> interrupt_request_two_o)
    else $error("capture without interrupt");
  ready_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_in_mode && !strobed_input_i && push |=> !p3_pin_o[PHS_L6])
    else $error("ready not lowered after capture");
  ready_rise_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_in_mode && $past(hs_in_mode) && $rose(p3_pin_o[PHS_L6]) |-> !$past(rd_valid_o) && $past(strobe_line))
    else $error("ready raised without read and strobe high");
  strobe_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(dav_out_q) |-> $past(strobe_line) && $past(hs_out_mode))
    else $error("strobe asserted while ready low");
  strobe_release_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_out_mode && state_q == PHS_WAIT && p3_fall[PHS_L1] |-> interrupt_request_two_o ##1 dav_out_q)
    else $error("ready fall not answered");
  held_data_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_out_mode && state_q != PHS_IDLE |=> $stable(drive_q))
    else $error("output data changed mid transfer");
  line_six_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_out_mode |-> p3_pin_o[PHS_L6] == dav_out_q)
    else $error("line 6 not owned by handshake");
  full_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    do_full_reset |=> p2_pin_oe_o == PHS_BYTE_ZERO && p3m_q == PHS_P3M_RESET)
    else $error("full reset left ports configured");

endmodule // phs_port_handshake

`default_nettype wire

// file: include/phs_pkg.sv
package phs_pkg;

  // ==========================================================
  // Register reset values
  localparam logic [7:0] PHS_P2M_RESET = 8'hFF;
  localparam logic [7:0] PHS_P3M_RESET = 8'h00;
  localparam logic [7:0] PHS_P3_OUT_RESET = 8'h00;
  localparam logic [7:0] PHS_BYTE_ZERO = 8'h00;

  // ==========================================================
  // Mode register field positions
  localparam int PHS_P3M_PUSHPULL_BIT = 0;
  localparam int PHS_P3M_ANALOG_BIT = 1;
  localparam int PHS_P3M_HS2_BIT = 6;
  localparam int PHS_P2_HS_DIR_BIT = 7;

  // ==========================================================
  // Port 3 line numbers
  localparam int PHS_L0 = 0;
  localparam int PHS_L1 = 1;
  localparam int PHS_L2 = 2;
  localparam int PHS_L3 = 3;
  localparam int PHS_L4 = 4;
  localparam int PHS_L5 = 5;
  localparam int PHS_L6 = 6;
  localparam int PHS_L7 = 7;

  // ==========================================================
  // Synchroniser and buffer sizes
  localparam int PHS_SYNC_W = 12;
  localparam int PHS_BUF_DEPTH = 2;
  localparam logic [1:0] PHS_CNT_ZERO = 2'h0;
  localparam logic [1:0] PHS_CNT_ONE = 2'h1;
  localparam logic [1:0] PHS_CNT_FULL = 2'h2;

  // ==========================================================
  // Handshake sequence states, one-hot
  typedef enum logic [2:0] {
    PHS_IDLE = 3'h1,
    PHS_WAIT = 3'h2,
    PHS_DONE = 3'h4
  } phs_state_t;

endpackage

// file: verif/phs_peripheral_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Byte peripheral on port 2 with a strobe and ready pair
module phs_peripheral_model (
  // Clock and behaviour
  input wire logic mclk_i,
  input wire logic send_i,
  input wire logic interlock_i,
  input wire logic [7:0] hold_i,
  // Lines
  input wire logic [7:0] port_i,
  input wire logic line_i,
  output logic [7:0] port_o,
  output logic hs_o,
  output logic [7:0] rx_o
);
  initial begin
    port_o = 8'hFF;
    hs_o = 1'b1;
    rx_o = 8'h00;
  end

  // Sender: data settles two cycles before the strobe falls
  task automatic send(input logic [7:0] d);
    int n;
    @(negedge mclk_i);
    port_o = d;
    repeat (2) @(negedge mclk_i);
    hs_o = 1'b0;
    if (interlock_i) begin
      for (n = 0; n < 60 && line_i !== 1'b0; n++) @(negedge mclk_i);
    end else begin
      repeat (4) @(negedge mclk_i);
    end
    hs_o = 1'b1;
    @(negedge mclk_i);
    // Released lines must not keep showing the old byte
    port_o = ~d;
    repeat (4) @(negedge mclk_i);
  endtask

  // Receiver: latch, drop ready, raise it only after the strobe is back high
  always begin
    @(negedge mclk_i);
    if (!send_i && line_i === 1'b0) begin
      @(negedge mclk_i);
      rx_o = port_i;
      hs_o = 1'b0;
      while (line_i !== 1'b1) @(negedge mclk_i);
      repeat (hold_i) @(negedge mclk_i);
      hs_o = 1'b1;
    end
  end
endmodule // phs_peripheral_model
`default_nettype wire

// file: verif/test_phs_port_handshake.sv
`timescale 1ns/100ps
`default_nettype none
module test_phs_port_handshake;
  logic mclk_i, rst_n_i, full_reset_i, stop_recovery_i, p2_rd_i, strobed_input_i, cmp_out_en_i, cmp1, cmp2;
  logic ser_en, ser_tx, spi_en, spi_sel, spi_clk, tmr_en, tmr_out, send, ilock, irq_clr;
  logic ser_rx, tmr_in, rd_valid, per_hs, tie, line1;
  logic [1:0] hs_st;
  logic [3:0] wr_sel, p3b, irq_v, irq_seen;
  logic [7:0] wd, hold, p2_rdata, p3_rdata, p2_pin, p2_oe, wire_p2, per_port, rx;
  logic [7:4] p3_out;
  int n_fail = 0;
  int total_checks = 0;
  int ln [4] = '{0, 1, 2, 3};
  int rq [4] = '{3, 2, 0, 1};

  // Each port 2 line carries whoever drives it
  assign wire_p2 = (p2_oe & p2_pin) | (~p2_oe & per_port);
  // Strobed output wiring feeds the strobe straight back as ready
  assign line1 = tie ? p3_out[6] : (per_hs & p3b[1]);

  phs_port_handshake phs_port_handshake_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .full_reset_i(full_reset_i), .stop_recovery_i(stop_recovery_i),
    .p2_wr_i(wr_sel[0]), .p2_wdata_i(wd), .p2_rd_i(p2_rd_i), .p2_rdata_o(p2_rdata), .rd_valid_o(rd_valid),
    .p2m_wr_i(wr_sel[1]), .p2m_wdata_i(wd), .p3m_wr_i(wr_sel[2]), .p3m_wdata_i(wd),
    .p3_wr_i(wr_sel[3]), .p3_wdata_i(wd), .p3_rdata_o(p3_rdata), .strobed_input_i(strobed_input_i),
    .cmp_out_en_i(cmp_out_en_i), .comparator_one_result_i(cmp1), .comparator_two_result_i(cmp2),
    .serial_en_i(ser_en), .serial_tx_i(ser_tx), .spi_en_i(spi_en), .spi_select_i(spi_sel),
    .spi_clock_line_i(spi_clk), .timer_out_en_i(tmr_en), .timer_out_i(tmr_out),
    .serial_receive_in_o(ser_rx), .timer_in_o(tmr_in), .interrupt_request_zero_o(irq_v[0]),
    .interrupt_request_one_o(irq_v[1]), .interrupt_request_two_o(irq_v[2]),
    .interrupt_request_three_o(irq_v[3]), .p2_pin_i(wire_p2), .p2_pin_o(p2_pin), .p2_pin_oe_o(p2_oe),
    .p3_pin_i({p3b[3:2], line1, p3b[0]}), .p3_pin_o(p3_out), .hs_state_o(hs_st)
  );

  phs_peripheral_model phs_peripheral_model_inst (
    .mclk_i(mclk_i), .send_i(send), .interlock_i(ilock), .hold_i(hold), .port_i(wire_p2),
    .line_i(p3_out[6]), .port_o(per_port), .hs_o(per_hs), .rx_o(rx)
  );

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Interrupt pulses last one cycle, so they are collected here
  always @(posedge mclk_i) irq_seen <= irq_clr ? 4'h0 : (irq_seen | irq_v);

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge mclk_i);
    wd = d;
    wr_sel = 4'h1 << sel;
    @(negedge mclk_i);
    wr_sel = 4'h0;
  endtask

  task automatic rd(input logic [7:0] exp);
    @(negedge mclk_i);
    chk(p2_rdata, exp);
    p2_rd_i = 1'b1;
    @(negedge mclk_i);
    p2_rd_i = 1'b0;
  endtask

  task automatic wait_line(input logic v);
    int k;
    for (k = 0; k < 80 && p3_out[6] !== v; k++) @(negedge mclk_i);
  endtask

  task automatic clr();
    @(negedge mclk_i);
    irq_clr = 1'b1;
    @(negedge mclk_i);
    irq_clr = 1'b0;
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole sequence needs well under 2000 cycles; 20000 marks a hang
  initial begin
    #800000;
    n_fail++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    {rst_n_i, full_reset_i, stop_recovery_i, p2_rd_i, strobed_input_i, cmp_out_en_i, cmp1, cmp2} = 8'h00;
    {ser_en, ser_tx, spi_en, spi_sel, spi_clk, tmr_en, tmr_out, irq_clr} = 8'h00;
    {tie, send, ilock, hold, wr_sel, wd, p3b} = {1'b0, 1'b1, 1'b1, 8'h00, 4'h0, 8'h00, 4'hF};
    repeat (16) @(negedge mclk_i);
    rst_n_i = 1'b1;
    @(negedge mclk_i);
    chk(p2_oe, 8'h00);
    chk({4'h0, p3_out}, 8'h00);
    for (int j = 0; j < 4; j++) begin
      clr();
      p3b[ln[j]] = 1'b0;
      repeat (8) @(negedge mclk_i);
      chk({4'h0, irq_seen}, 8'h01 << rq[j]);
      if (ln[j] == 0) chk({7'h0, ser_rx}, 8'h00);
      if (ln[j] == 1) chk({7'h0, tmr_in}, 8'h00);
      p3b[ln[j]] = 1'b1;
      repeat (8) @(negedge mclk_i);
    end
    // Input handshake
    wr(1, 8'hFF);
    wr(3, 8'h40);
    wr(2, 8'h41);
    wr(3, 8'h00);
    repeat (2) @(negedge mclk_i);
    chk({7'h0, p3_out[6]}, 8'h01);
    chk({7'h0, p3_rdata[6]}, 8'h01);
    clr();
    phs_peripheral_model_inst.send(8'hA5);
    chk({4'h0, irq_seen}, 8'h04);
    chk({7'h0, p3_out[6]}, 8'h00);
    ilock = 1'b0;
    phs_peripheral_model_inst.send(8'h3C);
    repeat (10) @(negedge mclk_i);
    chk({7'h0, p3_out[6]}, 8'h00);
    rd(8'hA5);
    wait_line(1'b1);
    chk({7'h0, p3_out[6]}, 8'h01);
    chk({7'h0, rd_valid}, 8'h00);
    // Output handshake with a slow receiver
    send = 1'b0;
    hold = 8'd20;
    wr(1, 8'h00);
    clr();
    wr(0, 8'h5A);
    wait_line(1'b0);
    chk(p2_pin, 8'h5A);
    wait_line(1'b1);
    chk({7'h0, p3_out[6]}, 8'h01);
    chk({4'h0, irq_seen}, 8'h04);
    chk(rx, 8'h5A);
    wr(0, 8'hC3);
    wr(0, 8'hE7);
    repeat (2) @(negedge mclk_i);
    chk(p2_pin, 8'h5A);
    chk({7'h0, p3_out[6]}, 8'h01);
    wait_line(1'b0);
    chk(p2_pin, 8'hE7);
    wait_line(1'b1);
    repeat (30) @(negedge mclk_i);
    chk(rx, 8'hE7);
    // Full reset, blocked then taken
    send = 1'b1;
    stop_recovery_i = 1'b1;
    full_reset_i = 1'b1;
    @(negedge mclk_i);
    full_reset_i = 1'b0;
    stop_recovery_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(p2_oe, 8'hFF);
    full_reset_i = 1'b1;
    @(negedge mclk_i);
    full_reset_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(p2_oe, 8'h00);
    chk({4'h0, p3_out}, 8'h00);
    // Special functions on the upper lines
    {ser_en, spi_en, tmr_en, ser_tx, tmr_out, spi_sel, spi_clk} = 7'b1111010;
    repeat (2) @(negedge mclk_i);
    chk({4'h0, p3_out}, 8'h0A);
    {ser_tx, tmr_out, spi_sel, spi_clk} = 4'b0101;
    repeat (2) @(negedge mclk_i);
    chk({4'h0, p3_out}, 8'h05);
    {ser_en, spi_en, tmr_en, cmp_out_en_i, cmp1, cmp2} = 6'b000110;
    wr(2, 8'h02);
    repeat (2) @(negedge mclk_i);
    chk({4'h0, p3_out}, 8'h01);
    chk({6'h0, p3_rdata[2:1]}, 8'h01);
    {cmp1, cmp2} = 2'b01;
    repeat (2) @(negedge mclk_i);
    chk({4'h0, p3_out}, 8'h0A);
    chk({6'h0, p3_rdata[2:1]}, 8'h02);
    // Line 3 is the reference in analog mode and must stay quiet
    clr();
    p3b[3] = 1'b0;
    repeat (8) @(negedge mclk_i);
    chk({4'h0, irq_seen}, 8'h00);
    p3b[3] = 1'b1;
    // Strobed input fills the buffer, third byte refused
    cmp_out_en_i = 1'b0;
    wr(1, 8'hFF);
    wr(3, 8'h40);
    wr(2, 8'h41);
    strobed_input_i = 1'b1;
    phs_peripheral_model_inst.send(8'h11);
    phs_peripheral_model_inst.send(8'h22);
    phs_peripheral_model_inst.send(8'h33);
    chk({7'h0, rd_valid}, 8'h01);
    rd(8'h11);
    rd(8'h22);
    @(negedge mclk_i);
    chk({7'h0, rd_valid}, 8'h00);
    // Strobed output: each write makes one self-ending strobe pulse
    tie = 1'b1;
    wr(1, 8'h00);
    clr();
    wr(0, 8'h96);
    chk({6'h0, hs_st}, 8'h01);
    chk(p2_pin, 8'h96);
    wait_line(1'b1);
    chk({6'h0, hs_st}, 8'h02);
    repeat (8) @(negedge mclk_i);
    chk({6'h0, hs_st}, 8'h00);
    chk({4'h0, irq_seen}, 8'h04);
    summarize();
  end
endmodule // test_phs_port_handshake
`default_nettype wire
